//--- design/fbf_pkg.sv
// Purpose: shared constants for the fault-current breaker-failure block
// Assumes: 32-bit AXI4-Lite register access, 100 MHz system clock
// Notes: register offsets are byte addresses
package fbf_pkg;
  localparam int NUM_PHASES = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TMR_W = 16;
  localparam int TS_W = 32;
  localparam int LOG_DEPTH = 16;
  localparam int LOG_PTR_W = 4;
  // processing tick: one quarter power cycle at 60 Hz
  localparam int TICK_PERIOD_NS = 4166667;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 24;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_FC_DELAY = 8'h04;
  localparam logic [ADDR_W-1:0] REG_TT_DELAY = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h14;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 8'h18;
  localparam logic [ADDR_W-1:0] REG_LOG_COUNT = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_LOG_DATA = 8'h20;
  localparam logic [ADDR_W-1:0] REG_LOG_TIME = 8'h24;
  localparam logic [ADDR_W-1:0] REG_LOG_POP = 8'h28;

  // control field layout
  localparam int CTRL_SCHEME_LSB = 0;
  localparam int CTRL_SCHEME_W = 2;
  localparam int CTRL_CONTACT_EN = 4;
  localparam logic [CTRL_SCHEME_W-1:0] SCHEME_1 = 2'h1;
  localparam logic [CTRL_SCHEME_W-1:0] SCHEME_2 = 2'h2;
  localparam logic [CTRL_SCHEME_W-1:0] SCHEME_3 = 2'h3;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000011;
  localparam logic [TMR_W-1:0] FC_DELAY_RESET = 16'h0020;
  localparam logic [TMR_W-1:0] TT_DELAY_RESET = 16'h0008;

  // irq bits: failure per phase, event-report trigger, log overflow
  localparam int IRQ_W = 5;
  localparam int IRQ_FAIL_LSB = 0;
  localparam int IRQ_REPORT = 3;
  localparam int IRQ_OVERFLOW = 4;

  // logged element word: request_input_a[2:0], overcurrent[5:3], failure[8:6]
  localparam int ELEM_W = 9;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- design/fbf_breaker_failure.sv
// Purpose: per-phase fault-current breaker-failure logic, schemes 1 to 3
// Assumes: request_input_a and overcurrent inputs come from pins (3-flop filtered)
// Notes: timers count processing ticks; one AXI4-Lite slave for settings
// Function
// R1 - one scheme active at a time, chosen by select value 1, 2 or 3
// R2 - request_input_a plus overcurrent on a phase runs that phase's fault-clear timer
// R3 - timer reaching pickup delay with conditions present asserts failure bit
// R4 - current dropping before timer expiry keeps failure bit off
// R5 - scheme 1: current must appear before request_input_a-extension dropout expires
// R6 - scheme 1: failure bit held for dropout delay after request_input_a deasserts
// R7 - scheme 3: request_input_a not latched; early request_input_a drop keeps failure bit off
// R8 - phases A, B, C evaluated independently and identically
// R9 - scheme 2: request_input_a-to-failure interval equals pickup delay
// R10 - schemes 2 and 3: overcurrent rising edge triggers event report
// R11 - every change of logged elements is time-stamped in the event log; changes while the log is full are dropped and raise the overflow irq
// R12 - output contact follows failure bit when configured to
// R13 - all timers count on a fixed periodic tick, delays from settings
`timescale 1ns/10ps
module fbf_breaker_failure
#(
  parameter int TICK_CYCLES = fbf_pkg::TICK_CYCLES_DEF
)
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [fbf_pkg::NUM_PHASES-1:0] request_input_i,
  input wire logic [fbf_pkg::NUM_PHASES-1:0] fault_overcurrent_detect_i,
  output logic [fbf_pkg::NUM_PHASES-1:0] fault_breaker_failure_bit_o,
  output logic output_contact_o,
  output logic event_report_o,
  output logic irq_o,
  input wire logic [fbf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [fbf_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [fbf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [fbf_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import fbf_pkg::*;

  // ----------------------------------------
  // input filtering
  // ----------------------------------------
  logic [NUM_PHASES-1:0] request_input_a_s1, request_input_a_s2, request_input_a_s3, request_input_a_f;
  logic [NUM_PHASES-1:0] oc_s1, oc_s2, oc_s3, oc_f;
  logic [NUM_PHASES-1:0] next_request_input_a_f, next_oc_f;

  always_comb
  begin
    // a change counts once stages two and three agree
    next_request_input_a_f = request_input_a_f;
    next_oc_f = oc_f;
    for (int i = 0; i < NUM_PHASES; i++)
    begin
      if (request_input_a_s2[i] == request_input_a_s3[i])
        next_request_input_a_f[i] = request_input_a_s2[i];
      if (oc_s2[i] == oc_s3[i])
        next_oc_f[i] = oc_s2[i];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      request_input_a_s1 <= '0;
      request_input_a_s2 <= '0;
      request_input_a_s3 <= '0;
      request_input_a_f <= '0;
      oc_s1 <= '0;
      oc_s2 <= '0;
      oc_s3 <= '0;
      oc_f <= '0;
    end
    else
    begin
      request_input_a_s1 <= request_input_i;
      request_input_a_s2 <= request_input_a_s1;
      request_input_a_s3 <= request_input_a_s2;
      request_input_a_f <= next_request_input_a_f;
      oc_s1 <= fault_overcurrent_detect_i;
      oc_s2 <= oc_s1;
      oc_s3 <= oc_s2;
      oc_f <= next_oc_f;
    end
  end

  // ----------------------------------------
  // processing tick and time stamp
  // ----------------------------------------
  logic [TICK_CNT_W-1:0] tick_cnt, next_tick_cnt;
  logic tick, next_tick;
  logic [TS_W-1:0] time_stamp, next_time_stamp;

  // R13 periodic tick
  always_comb
  begin
    next_tick = (tick_cnt == TICK_CNT_W'(TICK_CYCLES - 1));
    next_tick_cnt = next_tick ? '0 : tick_cnt + 1'b1;
    next_time_stamp = time_stamp + 1'b1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      tick_cnt <= '0;
      tick <= 1'b0;
      time_stamp <= '0;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
      time_stamp <= next_time_stamp;
    end
  end

  // ----------------------------------------
  // settings
  // ----------------------------------------
  logic [DATA_W-1:0] ctrl;
  logic [TMR_W-1:0] fault_clear_pickup_delay, request_input_a_extend_dropout_delay;
  logic [CTRL_SCHEME_W-1:0] fault_scheme_select;

  // R1 single scheme; code 0 disables all
  assign fault_scheme_select = ctrl[CTRL_SCHEME_LSB +: CTRL_SCHEME_W];

  // ----------------------------------------
  // per-phase logic
  // ----------------------------------------
  logic [NUM_PHASES-1:0] fbf, oc_rise;
  logic [NUM_PHASES-1:0] oc_d, next_oc_d;

  assign next_oc_d = oc_f;
  assign oc_rise = oc_f & ~oc_d;

  // R8 identical per-phase copies
  for (genvar p = 0; p < NUM_PHASES; p++)
  begin : g_phase
    logic [TMR_W-1:0] fault_clear_timer, next_fault_clear_timer;
    logic [TMR_W-1:0] request_input_a_extend_dropout_timer, next_request_input_a_extend_dropout_timer;
    logic request_input_a_ext, start, fail, next_fail;

    always_comb
    begin
      // R5 R6 scheme 1 stretches request_input_a by dropout delay
      request_input_a_ext = request_input_a_f[p] || (request_input_a_extend_dropout_timer != '0);
      next_request_input_a_extend_dropout_timer = request_input_a_extend_dropout_timer;
      // idle outside scheme 1, so a scheme change never fakes a request_input_a
      if (fault_scheme_select != SCHEME_1)
        next_request_input_a_extend_dropout_timer = '0;
      else if (request_input_a_f[p])
        next_request_input_a_extend_dropout_timer = request_input_a_extend_dropout_delay;
      else if (tick && request_input_a_extend_dropout_timer != '0)
        next_request_input_a_extend_dropout_timer = request_input_a_extend_dropout_timer - 1'b1;
      unique case (fault_scheme_select)
        SCHEME_1: start = request_input_a_ext && (oc_f[p] || fail);
        // R7 scheme 3 unlatched; R9 scheme 2 times from request_input_a
        SCHEME_2, SCHEME_3: start = request_input_a_f[p] && oc_f[p];
        default: start = 1'b0;
      endcase
      // R2 R4 timer runs only while conditions hold
      next_fault_clear_timer = '0;
      next_fail = 1'b0;
      if (start)
      begin
        next_fault_clear_timer = fault_clear_timer;
        if (tick && fault_clear_timer != fault_clear_pickup_delay)
          next_fault_clear_timer = fault_clear_timer + 1'b1;
        // R3 assert at pickup
        next_fail = (fault_clear_timer == fault_clear_pickup_delay);
        // R6 hold through dropout while request_input_a extended
        if (fault_scheme_select == SCHEME_1 && fail)
          next_fail = 1'b1;
      end
    end

    always_ff @(posedge sys_clk_i)
    begin
      if (reset_i)
      begin
        fault_clear_timer <= '0;
        request_input_a_extend_dropout_timer <= '0;
        fail <= 1'b0;
      end
      else
      begin
        fault_clear_timer <= next_fault_clear_timer;
        request_input_a_extend_dropout_timer <= next_request_input_a_extend_dropout_timer;
        fail <= next_fail;
      end
    end

    assign fbf[p] = fail;
  end

  // ----------------------------------------
  // outputs, report trigger, event log
  // ----------------------------------------
  logic report, next_report;
  logic contact, next_contact;
  logic [ELEM_W-1:0] elem, elem_d;
  logic [TS_W+ELEM_W-1:0] log_mem [LOG_DEPTH];
  logic [LOG_PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [LOG_PTR_W:0] log_cnt, next_log_cnt;
  logic log_push, log_pop, log_full;

  assign elem = {fbf, oc_f, request_input_a_f};
  // R11 log any element change while the log is not full
  assign log_push = (elem != elem_d) && !log_full;
  assign log_full = (log_cnt == (LOG_PTR_W+1)'(LOG_DEPTH));

  always_comb
  begin
    // R10 report on overcurrent rise in schemes 2 and 3
    next_report = (|oc_rise) &&
      (fault_scheme_select == SCHEME_2 || fault_scheme_select == SCHEME_3);
    // R12 contact follows failure bit when enabled
    next_contact = ctrl[CTRL_CONTACT_EN] && (|fbf);
    next_wr_ptr = wr_ptr + LOG_PTR_W'(log_push);
    next_rd_ptr = rd_ptr + LOG_PTR_W'(log_pop);
    next_log_cnt = log_cnt + (LOG_PTR_W+1)'(log_push) - (LOG_PTR_W+1)'(log_pop);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      oc_d <= '0;
      elem_d <= '0;
      report <= 1'b0;
      contact <= 1'b0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      log_cnt <= '0;
    end
    else
    begin
      oc_d <= next_oc_d;
      elem_d <= elem;
      report <= next_report;
      contact <= next_contact;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      log_cnt <= next_log_cnt;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (log_push)
      log_mem[wr_ptr] <= {time_stamp, elem};
  end

  assign fault_breaker_failure_bit_o = fbf;
  assign output_contact_o = contact;
  assign event_report_o = report;

  // ----------------------------------------
  // interrupts and AXI4-Lite slave
  // ----------------------------------------
  logic [IRQ_W-1:0] irq_status, irq_enable, irq_set, irq_clr;
  logic [IRQ_W-1:0] next_irq_status, next_irq_enable;
  logic [DATA_W-1:0] next_ctrl;
  logic [TMR_W-1:0] next_fc_delay, next_tt_delay;
  logic aw_hold, w_hold, next_aw_hold, next_w_hold;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [DATA_W-1:0] w_data, next_w_data;
  logic next_bvalid, next_rvalid, wr_go, rd_go;
  logic [1:0] next_bresp, next_rresp;
  logic [DATA_W-1:0] next_rdata;

  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign log_pop = wr_go && aw_addr == REG_LOG_POP && log_cnt != '0;
  assign irq_set = {(elem != elem_d) && log_full, next_report,
    fbf & ~elem_d[ELEM_W-1 -: NUM_PHASES]};
  assign irq_o = |(irq_status & irq_enable);

  always_comb
  begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
    end
    next_ctrl = ctrl;
    next_fc_delay = fault_clear_pickup_delay;
    next_tt_delay = request_input_a_extend_dropout_delay;
    next_irq_enable = irq_enable;
    irq_clr = '0;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    if (wr_go)
    begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      unique case (aw_addr)
        REG_CTRL: next_ctrl = w_data;
        REG_FC_DELAY: next_fc_delay = w_data[TMR_W-1:0];
        REG_TT_DELAY: next_tt_delay = w_data[TMR_W-1:0];
        REG_IRQ_ENABLE: next_irq_enable = w_data[IRQ_W-1:0];
        REG_IRQ_CLEAR: irq_clr = w_data[IRQ_W-1:0];
        REG_LOG_POP: ;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    // set wins over clear
    next_irq_status = (irq_status & ~irq_clr) | irq_set;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (rd_go)
    begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      unique case (s_axi_araddr)
        REG_CTRL: next_rdata = ctrl;
        REG_FC_DELAY: next_rdata = DATA_W'(fault_clear_pickup_delay);
        REG_TT_DELAY: next_rdata = DATA_W'(request_input_a_extend_dropout_delay);
        REG_STATE: next_rdata = DATA_W'(elem);
        REG_IRQ_STATUS: next_rdata = DATA_W'(irq_status);
        REG_IRQ_ENABLE: next_rdata = DATA_W'(irq_enable);
        REG_LOG_COUNT: next_rdata = DATA_W'(log_cnt);
        REG_LOG_DATA: next_rdata = DATA_W'(log_mem[rd_ptr][ELEM_W-1:0]);
        REG_LOG_TIME: next_rdata = log_mem[rd_ptr][TS_W+ELEM_W-1:ELEM_W];
        REG_IRQ_CLEAR, REG_LOG_POP: ;
        default: next_rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      ctrl <= CTRL_RESET;
      fault_clear_pickup_delay <= FC_DELAY_RESET;
      request_input_a_extend_dropout_delay <= TT_DELAY_RESET;
      irq_status <= '0;
      irq_enable <= '0;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
    end
    else
    begin
      ctrl <= next_ctrl;
      fault_clear_pickup_delay <= next_fc_delay;
      request_input_a_extend_dropout_delay <= next_tt_delay;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end
endmodule

//--- tb/fbf_partner.sv
// Purpose: breaker request_input_a contacts and overcurrent elements
// Assumes: the bench sets the wanted level of each phase
// Notes: levels change just after an edge, as slow contacts would
`timescale 1ns/10ps
module fbf_partner
(
  input logic sys_clk_i,
  input logic [2:0] request_input_a_cmd_i,
  input logic [2:0] oc_cmd_i,
  output logic [2:0] request_input_o,
  output logic [2:0] fault_overcurrent_detect_o
);
  always_ff @(posedge sys_clk_i)
  begin
    request_input_o <= request_input_a_cmd_i;
    fault_overcurrent_detect_o <= oc_cmd_i;
  end
endmodule

//--- tb/fbf_assertions.sv
// Purpose: port checks for the breaker failure block
// Assumes: one clock, synchronous reset
// Notes: age counters stand in for the pin filter delay
`timescale 1ns/10ps
module fbf_checker
#(
  parameter int TICK_CYCLES = 4
)
(
  input logic sys_clk_i,
  input logic reset_i,
  input logic [2:0] fault_overcurrent_detect_i,
  input logic [2:0] fault_breaker_failure_bit_o,
  input logic output_contact_o,
  input logic event_report_o,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [31:0] s_axi_rdata
);
  logic [3:0] any_age;
  logic [3:0] a_age;
  // cycles since an overcurrent pin was last high, saturating
  always_ff @(posedge sys_clk_i)
  begin
    any_age <= (reset_i) ? 4'hF : (|fault_overcurrent_detect_i) ? 4'h0
               : any_age + {3'h0, ~&any_age};
    a_age <= (reset_i) ? 4'hF : (fault_overcurrent_detect_i[0]) ? 4'h0
             : a_age + {3'h0, ~&a_age};
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  property p_contact; output_contact_o |-> $past(|fault_breaker_failure_bit_o); endproperty
  a_contact: assert property (p_contact) else $error("contact without failure bit");
  property p_fail_cause; $rose(fault_breaker_failure_bit_o[0]) |-> a_age <= 4'h8; endproperty
  a_fail_cause: assert property (p_fail_cause) else $error("failure without current");
  property p_rep_cause; event_report_o |-> any_age <= 4'h8; endproperty
  a_rep_cause: assert property (p_rep_cause) else $error("report without current");
  property p_rep_pulse; event_report_o |=> !event_report_o; endproperty
  a_rep_pulse: assert property (p_rep_pulse) else $error("report longer than a cycle");
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read response late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  c_fail: cover property ($rose(fault_breaker_failure_bit_o[0]));
  c_report: cover property (event_report_o);
  c_contact: cover property ($rose(output_contact_o));
endmodule
bind fbf_breaker_failure fbf_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.*);

//--- tb/tb_fault_current_breaker_failure.sv
// Purpose: self-checking bench for the breaker failure block
// Assumes: tick cut to 4 clocks
// Notes: timing windows allow one tick of slack
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_fault_current_breaker_failure;
  import fbf_pkg::*;
  localparam int TK = 4;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [2:0] request_input_a_cmd = 3'h0, oc_cmd = 3'h0, request_input_a_w, oc_w, fail, fail_smp;
  logic contact, report, irq;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [15:0] lfsr = 16'h4EDB;
  int mismatches = 0, compares = 0, cycles = 0, reports = 0, n, d, p, sch, r0;
  fbf_partner pm_u (.sys_clk_i, .request_input_a_cmd_i(request_input_a_cmd), .oc_cmd_i(oc_cmd),
    .request_input_o(request_input_a_w), .fault_overcurrent_detect_o(oc_w));
  fbf_breaker_failure #(.TICK_CYCLES(TK)) dut_u (.sys_clk_i, .reset_i,
    .request_input_i(request_input_a_w), .fault_overcurrent_detect_i(oc_w),
    .fault_breaker_failure_bit_o(fail), .output_contact_o(contact),
    .event_report_o(report), .irq_o(irq), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial
    forever #5 sys_clk_i = ~sys_clk_i;
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic in_win(input int v, input int lo, input int hi);
    return v >= lo && v <= hi;
  endfunction
  task automatic test_done;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // handshakes sampled at the falling edge, so never racing the slave
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    logic aw, w, b;
    b = 1'b0;
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= lfsr[0];
    while (!b)
    begin
      @(negedge sys_clk_i);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid & s_axi_bready;
      r = s_axi_bresp;
      @(posedge sys_clk_i);
      s_axi_awvalid <= s_axi_awvalid & ~aw;
      s_axi_wvalid <= s_axi_wvalid & ~w;
      s_axi_bready <= ~b;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic ar, g;
    g = 1'b0;
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= lfsr[1];
    while (!g)
    begin
      @(negedge sys_clk_i);
      ar = s_axi_arvalid & s_axi_arready;
      g = s_axi_rvalid & s_axi_rready;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk_i);
      s_axi_arvalid <= s_axi_arvalid & ~ar;
      s_axi_rready <= ~g;
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, rd_d, resp);
    `CHK(rd_d, e)
  endtask
  task automatic wait_fail(input int ph, input logic v, output int k);
    k = 0;
    @(negedge sys_clk_i);
    while (fail[ph] !== v && k < 200)
    begin
      @(negedge sys_clk_i);
      k++;
    end
    fail_smp = fail;
    @(posedge sys_clk_i);
  endtask
  always @(negedge sys_clk_i)
    if (report === 1'b1)
      reports <= reports + 1;
  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      mismatches++;
      test_done();
    end
  end
  // --
  // main sequence
  // --
  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rchk(REG_CTRL, CTRL_RESET);
    rchk(REG_FC_DELAY, {16'h0, FC_DELAY_RESET});
    rchk(REG_TT_DELAY, {16'h0, TT_DELAY_RESET});
    rd(8'h40, rd_d, resp);
    `CHK(resp, RESP_SLVERR)
    wr(8'h44, 32'hFFFF, resp);
    `CHK(resp, RESP_SLVERR)
    request_input_a_cmd <= 3'h1;
    repeat (12) @(posedge sys_clk_i);
    rchk(REG_LOG_COUNT, 32'h1);
    rchk(REG_LOG_DATA, 32'h1);
    wr(REG_LOG_POP, 32'h0, resp);
    rchk(REG_LOG_COUNT, 32'h0);
    request_input_a_cmd <= 3'h0;
    repeat (12 * TK) @(posedge sys_clk_i);
    for (int i = 0; i < 12; i++)
    begin
      lfsr = lfsr_next(lfsr);
      sch = i % 4;
      p = lfsr[5:4] % 3;
      d = 2 + lfsr[8:6];
      wr(REG_CTRL, 32'h10 | sch, resp);
      wr(REG_FC_DELAY, d, resp);
      r0 = reports;
      oc_cmd[p] <= 1'b1;
      repeat (10) @(posedge sys_clk_i);
      `CHK(reports - r0, int'(sch >= 2))
      request_input_a_cmd[p] <= 1'b1;
      if (i / 4 == 1)
      begin
        repeat ((d - 1) * TK - 2) @(posedge sys_clk_i);
        if (sch == 3)
          request_input_a_cmd[p] <= 1'b0;
        else
          oc_cmd[p] <= 1'b0;
      end
      wait_fail(p, 1'b1, n);
      if (sch == 0 || i / 4 == 1)
        `CHK(fail_smp[p], 1'b0)
      else
      begin
        `CHK(in_win(n, d * TK + 2, d * TK + TK + 6), 1'b1)
        `CHK(fail_smp & ~(3'h1 << p), 3'h0)
        @(negedge sys_clk_i);
        `CHK(contact, 1'b1)
        @(posedge sys_clk_i);
        request_input_a_cmd[p] <= 1'b0;
        wait_fail(p, 1'b0, n);
        if (sch == 1)
          `CHK(in_win(n, 7 * TK + 4, 9 * TK + 6), 1'b1)
        else
          `CHK(in_win(n, 3, 7), 1'b1)
        wr(REG_IRQ_ENABLE, 32'h0, resp);
        @(negedge sys_clk_i);
        `CHK(irq, 1'b0)
        wr(REG_IRQ_ENABLE, 32'h7, resp);
        rd(REG_IRQ_STATUS, rd_d, resp);
        `CHK(rd_d[2:0], 3'h1 << p)
        @(negedge sys_clk_i);
        `CHK(irq, 1'b1)
        wr(REG_IRQ_CLEAR, 32'h1F, resp);
        @(negedge sys_clk_i);
        `CHK(irq, 1'b0)
      end
      @(posedge sys_clk_i);
      oc_cmd[p] <= 1'b0;
      request_input_a_cmd[p] <= 1'b0;
      repeat (12 * TK) @(posedge sys_clk_i);
    end
    // current after the request_input_a has gone: only while the extension runs
    wr(REG_CTRL, 32'h11, resp);
    wr(REG_FC_DELAY, 32'h1, resp);
    wr(REG_TT_DELAY, 32'h4, resp);
    for (int k = 0; k < 2; k++)
    begin
      request_input_a_cmd <= 3'h2;
      repeat (8) @(posedge sys_clk_i);
      request_input_a_cmd <= 3'h0;
      repeat (k ? 7 * TK : TK) @(posedge sys_clk_i);
      oc_cmd <= 3'h2;
      wait_fail(1, 1'b1, n);
      `CHK(fail_smp[1], k ? 1'b0 : 1'b1)
      oc_cmd <= 3'h0;
      repeat (10 * TK) @(posedge sys_clk_i);
    end
    test_done();
  end
endmodule
